/* File: pin5_pkg.sv */
// Constants, register map and option codes for the pin five output block.
// Assumes a 200 MHz system clock and a 16-bit scale where 32000 is 100 %.
package pin5_pkg;

    // Clock and frequency output scaling
    localparam int unsigned CLK_HZ       = 200_000_000;
    localparam int unsigned FREQ_FULL_HZ = 10_000;   // Frequency at 100 % flow
    localparam int unsigned SCALE_FULL   = 32_000;   // Raw value for 100 %
    // Accumulator limit: one toggle per limit, so 100 % gives FREQ_FULL_HZ
    localparam logic [28:0] FREQ_LIMIT =
        29'(SCALE_FULL * (CLK_HZ / (2 * FREQ_FULL_HZ)));
    localparam logic [15:0] MEASURE_MAX = 16'(SCALE_FULL);

    // Setpoint thresholds: 1.9 % for analog control, above zero for digital
    localparam int unsigned SP_ANALOG_PERMILLE = 19;
    localparam logic [15:0] SP_ANALOG_MIN =
        16'((SCALE_FULL * SP_ANALOG_PERMILLE + 999) / 1000);
    localparam logic [15:0] SP_DIGITAL_MIN = 16'h0001;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_SETPOINT = 8'h10;
    localparam logic [7:0] ADDR_MEASURE  = 8'h14;

    // Field positions
    localparam int unsigned CTRL_SWITCH_BIT  = 0;
    localparam int unsigned STAT_PIN_BIT     = 0;
    localparam int unsigned STAT_FAIL_BIT    = 1;
    localparam int unsigned STAT_WAVE_BIT    = 2;
    localparam int unsigned STAT_ANALOG_BIT  = 3;
    localparam int unsigned STAT_OPTION_LSB  = 8;
    localparam int unsigned IRQ_MINMAX_BIT   = 0;
    localparam int unsigned IRQ_COUNTER_BIT  = 1;
    localparam int unsigned IRQ_FAILSAFE_BIT = 2;
    localparam int unsigned IRQ_PIN_BIT      = 3;
    localparam int unsigned IRQ_WIDTH        = 4;

    // Reset values
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    localparam logic       SWITCH_RESET   = 1'b0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Factory option selection
    typedef enum logic [2:0] {
        OPT_DISABLED      = 3'h0,
        OPT_MINMAX_ALARM  = 3'h1,
        counter_alarm_output_option   = 3'h2,
        setpoint_enabled_output_option = 3'h3,
        OPT_REMOTE_SWITCH = 3'h4,
        frequency_output_option       = 3'h5
    } option_t;

endpackage

/* File: pin5_output.sv */
// Pin five output driver with AXI4-Lite register access and interrupt.
// Assumes alarm, setpoint, measurement and fail-safe inputs come from
// logic on aclk, and that option_code is strapped before reset release.

module pin5_output
    import pin5_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [2:0]  option_code,
    input  wire logic        minmax_alarm,
    input  wire logic        counter_alarm,
    input  wire logic        analog_control,
    input  wire logic [15:0] setpoint,
    input  wire logic [15:0] measure,
    input  wire logic        failsafe,
    output logic             pin5_o,
    output logic             pin5_oe,
    output logic             irq
);

    option_t               option_q;
    logic [2:0]            opt_sync1_q;   // Strap pin synchroniser stages
    logic [2:0]            opt_sync2_q;
    logic [2:0]            opt_sync3_q;
    logic                  switch_q;
    logic [IRQ_WIDTH-1:0]  irq_stat_q;
    logic [IRQ_WIDTH-1:0]  irq_stat_d;
    logic [IRQ_WIDTH-1:0]  irq_mask_q;
    logic [IRQ_WIDTH-1:0]  irq_clr;
    logic [IRQ_WIDTH-1:0]  events;
    logic                  minmax_prev_q;
    logic                  counter_prev_q;
    logic                  fail_prev_q;
    logic                  pin_prev_q;
    logic                  drive_d;
    logic                  drive_q;
    logic                  wave_q;
    logic [28:0]           acc_q;
    logic [28:0]           acc_sum;
    logic [15:0]           meas_clamped;
    logic                  aw_have_q;
    logic                  w_have_q;
    logic [7:0]            aw_addr_q;
    logic [31:0]           w_data_q;
    logic                  w_en_q;
    logic                  wr_fire;
    logic                  wr_ok;
    logic                  wr_ctrl;
    logic                  wr_clear;
    logic                  wr_mask;
    logic [31:0]           rd_data;
    logic                  rd_ok;

    // Strap pins pass three flip-flops before they are trusted
    always_ff @(posedge aclk)
    begin
        opt_sync1_q <= option_code;
        opt_sync2_q <= opt_sync1_q;
        opt_sync3_q <= opt_sync2_q;
    end

    // Option code is latched while reset is held and never written later
    always_ff @(posedge aclk)
    begin
        if (!aresetn && opt_sync2_q == opt_sync3_q)
            option_q <= option_t'(opt_sync3_q);
    end

    // Clamp measurement to full scale before it feeds the accumulator
    always_comb
    begin
        meas_clamped = (measure > MEASURE_MAX) ? MEASURE_MAX : measure;
        acc_sum      = acc_q + {13'h0000, meas_clamped};
    end

    // Rate accumulator: toggles the wave each time the limit is passed
    always_ff @(posedge aclk)
    begin
        if (!aresetn || option_q != frequency_output_option)
        begin
            acc_q  <= 29'h00000000;
            wave_q <= 1'b1;
        end
        else if (meas_clamped == 16'h0000)
        begin
            acc_q  <= 29'h00000000;   // Zero flow parks the pin released
            wave_q <= 1'b1;
        end
        else if (acc_sum >= FREQ_LIMIT)
        begin
            acc_q  <= acc_sum - FREQ_LIMIT;
            wave_q <= ~wave_q;
        end
        else
        begin
            acc_q <= acc_sum;
        end
    end

    // Pull-down request per installed option
    always_comb
    begin
        case (option_q)
            OPT_DISABLED:
                drive_d = 1'b1;
            OPT_MINMAX_ALARM:
                drive_d = minmax_alarm;
            counter_alarm_output_option:
                drive_d = counter_alarm;
            setpoint_enabled_output_option:
                // Fail-safe deliberately not looked at here
                if (analog_control)
                    drive_d = (setpoint >= SP_ANALOG_MIN);
                else
                    drive_d = (setpoint >= SP_DIGITAL_MIN);
            OPT_REMOTE_SWITCH:
                drive_d = switch_q && !failsafe;
            frequency_output_option:
                drive_d = !wave_q;
            default:
                drive_d = 1'b0;
        endcase
    end

    // Registered pin enable; output level is always low when enabled
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            drive_q <= 1'b0;
            pin5_oe <= 1'b0;
            pin5_o  <= 1'b0;
        end
        else
        begin
            drive_q <= drive_d;
            pin5_oe <= drive_d;
            pin5_o  <= 1'b0;
        end
    end

    // Edge history for interrupt events
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            minmax_prev_q  <= 1'b0;
            counter_prev_q <= 1'b0;
            fail_prev_q    <= 1'b0;
            pin_prev_q     <= 1'b0;
        end
        else
        begin
            minmax_prev_q  <= minmax_alarm;
            counter_prev_q <= counter_alarm;
            fail_prev_q    <= failsafe;
            pin_prev_q     <= drive_q;
        end
    end

    // Events: alarm rises, fail-safe entry, any pin change
    always_comb
    begin
        events                   = '0;
        events[IRQ_MINMAX_BIT]   = minmax_alarm && !minmax_prev_q;
        events[IRQ_COUNTER_BIT]  = counter_alarm && !counter_prev_q;
        events[IRQ_FAILSAFE_BIT] = failsafe && !fail_prev_q;
        events[IRQ_PIN_BIT]      = drive_q != pin_prev_q;
    end

    // Write decode
    always_comb
    begin
        wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
        wr_ok   = (aw_addr_q == ADDR_CTRL) || (aw_addr_q == ADDR_STATUS)
               || (aw_addr_q == ADDR_IRQ_STAT) || (aw_addr_q == ADDR_IRQ_MASK)
               || (aw_addr_q == ADDR_SETPOINT) || (aw_addr_q == ADDR_MEASURE);
        wr_ctrl  = wr_fire && w_en_q && (aw_addr_q == ADDR_CTRL);
        wr_clear = wr_fire && w_en_q && (aw_addr_q == ADDR_IRQ_STAT);
        wr_mask  = wr_fire && w_en_q && (aw_addr_q == ADDR_IRQ_MASK);
        irq_clr = '0;
        if (wr_clear)
            irq_clr = w_data_q[IRQ_WIDTH-1:0];
        // A new event in the clearing cycle stays set
        irq_stat_d = (irq_stat_q & ~irq_clr) | events;
    end

    // Interrupt status, mask and output
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat_q <= '0;
            irq_mask_q <= IRQ_MASK_RESET;
            irq        <= 1'b0;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
            if (wr_mask)
                irq_mask_q <= w_data_q[IRQ_WIDTH-1:0];
            irq <= |(irq_stat_d & irq_mask_q);
        end
    end

    // Remote switch register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            switch_q <= SWITCH_RESET;
        else if (wr_ctrl)
            switch_q <= w_data_q[CTRL_SWITCH_BIT];
    end

    // Write address and data channels, taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h00000000;
            w_en_q        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q     <= 1'b1;
                aw_addr_q     <= {s_axi_awaddr[7:2], 2'h0};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_en_q       <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read mux; status and monitor words are read only
    always_comb
    begin
        rd_data = 32'h00000000;
        rd_ok   = 1'b1;
        case ({s_axi_araddr[7:2], 2'h0})
            ADDR_CTRL:
                rd_data[CTRL_SWITCH_BIT] = switch_q;
            ADDR_STATUS:
            begin
                rd_data[STAT_PIN_BIT]    = drive_q;
                rd_data[STAT_FAIL_BIT]   = failsafe;
                rd_data[STAT_WAVE_BIT]   = wave_q;
                rd_data[STAT_ANALOG_BIT] = analog_control;
                rd_data[STAT_OPTION_LSB +: 3] = option_q;
            end
            ADDR_IRQ_STAT:
                rd_data[IRQ_WIDTH-1:0] = irq_stat_q;
            ADDR_IRQ_MASK:
                rd_data[IRQ_WIDTH-1:0] = irq_mask_q;
            ADDR_SETPOINT:
                rd_data[15:0] = setpoint;
            ADDR_MEASURE:
                rd_data[15:0] = measure;
            default:
                rd_ok = 1'b0;
        endcase
    end

    // Read address and data channels
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // pin5_output

/* File: pin5_output_assertions.sv */
// Checker for the pin five output block: pin, reset and bus refusal.
// Assumes it is bound to pin5_output and sees only that module's ports.
module pin5_output_assertions
    import pin5_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [2:0]  option_code,
    input wire logic        minmax_alarm,
    input wire logic        counter_alarm,
    input wire logic        analog_control,
    input wire logic [15:0] setpoint,
    input wire logic        failsafe,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        pin5_o,
    input wire logic        pin5_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] opt_q;
    logic       sp_on;
    // Option as the block latches it while reset is low
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            opt_q <= option_code;
    end
    // Setpoint threshold of the active control source
    assign sp_on = analog_control ? (setpoint >= SP_ANALOG_MIN) : (setpoint >= SP_DIGITAL_MIN);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_disabled_low: assert property (aresetn && opt_q == OPT_DISABLED |=> pin5_oe)
        else $error("disabled option does not pull the pin low");
    a_minmax_follow: assert property (aresetn && opt_q == OPT_MINMAX_ALARM
        |=> pin5_oe == $past(minmax_alarm))
        else $error("pin does not follow the min/max alarm");
    a_counter_follow: assert property (aresetn && opt_q == counter_alarm_output_option
        |=> pin5_oe == $past(counter_alarm))
        else $error("pin does not follow the counter alarm");
    a_setpoint_thresh: assert property (aresetn && opt_q == setpoint_enabled_output_option
        |=> pin5_oe == $past(sp_on))
        else $error("pin does not follow the setpoint threshold");
    a_failsafe_release: assert property (aresetn && opt_q == OPT_REMOTE_SWITCH && failsafe
        |=> !pin5_oe)
        else $error("fail-safe does not release the switched pin");
    a_reset_release: assert property ($rose(aresetn) |-> !pin5_oe)
        else $error("pin driven while in reset");
    a_pin_level: assert property (pin5_o == 1'b0)
        else $error("pin output level is not low");
    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while a response is pending");
endmodule // pin5_output_assertions

bind pin5_output pin5_output_assertions u_chk (.aclk, .aresetn, .option_code, .minmax_alarm,
    .counter_alarm, .analog_control, .setpoint, .failsafe, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .pin5_o, .pin5_oe);

/* File: valve_model.sv */
// Pulse counter or shut-off valve hanging on pin five with a pull-up.
// Assumes one clock shared with the block; counts falling wire edges.
module valve_model
(
    input  wire logic  aclk,
    input  wire logic  clr,
    input  wire logic  pin5_o,
    input  wire logic  pin5_oe,
    output logic       pin_level,
    output logic [7:0] pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev_q;
    // Open drain wire: pulled up whenever the block releases it
    assign pin_level = pin5_oe ? pin5_o : 1'b1;
    // Falling edge counter as a pulse input would see it
    always_ff @(posedge aclk)
    begin
        prev_q <= pin_level;
        if (clr)
            pulses <= 8'h00;
        else if (prev_q && !pin_level)
            pulses <= pulses + 8'h01;
    end
endmodule // valve_model

/* File: pin5_output_tb_top.sv */
// Self-checking bench for pin5_output with a valve model on the pin.
// Assumes the checker is bound in; the option is strapped in reset.
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module pin5_output_tb_top
    import pin5_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [2:0] opt; logic [3:0] mcaf; logic [15:0] sp; logic exp;} row_t;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic mm = 0, ca = 0, an = 0, fs = 0, clr = 1, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 0, araddr = 0, pulses;
    logic [31:0] wdata = 0, rdata, d;
    logic [1:0] bresp, rresp, resp;
    logic [2:0] opt = 0;
    logic [15:0] sp = 0, meas = 0;
    logic pin5_o, pin5_oe, irq, level;
    int fail_count = 0, compares = 0, cyc = 0;
    // Option, min/max, counter, analog, fail-safe, setpoint, pin pulled low
    row_t rows[12] = '{{3'h0, 4'h0, 16'h0000, 1'b1}, {3'h1, 4'h8, 16'h0000, 1'b1},
        {3'h1, 4'h0, 16'h0000, 1'b0}, {3'h2, 4'h4, 16'h0000, 1'b1},
        {3'h2, 4'h0, 16'h0000, 1'b0}, {3'h3, 4'h2, 16'h025F, 1'b0},
        {3'h3, 4'h2, 16'h0260, 1'b1}, {3'h3, 4'h0, 16'h0001, 1'b1},
        {3'h3, 4'h0, 16'h0000, 1'b0}, {3'h3, 4'h3, 16'h0260, 1'b1},
        {3'h4, 4'h0, 16'h0000, 1'b0}, {3'h6, 4'h8, 16'h0000, 1'b0}};
    pin5_output dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .option_code(opt), .minmax_alarm(mm), .counter_alarm(ca), .analog_control(an),
        .setpoint(sp), .measure(meas), .failsafe(fs), .pin5_o, .pin5_oe, .irq);
    valve_model u_valve (.aclk, .clr, .pin5_o, .pin5_oe, .pin_level(level), .pulses);
    // Clock and hang guard
    always #2.5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            fail_count++;
            final_report();
        end
    end
    // Reset held six cycles with a new option strapped
    task automatic do_reset(input logic [2:0] o);
        opt <= o;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    // Bus write; address and data released each at its own take
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 1'b0;
    endtask
    // Bus read; data taken at the rvalid edge
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic final_report();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        foreach (rows[i])
        begin
            {mm, ca, an, fs} <= rows[i].mcaf;
            sp <= rows[i].sp;
            do_reset(rows[i].opt);
            `CHK(pin5_oe, 1'b0)
            repeat (3) @(posedge aclk);
            `CHK(pin5_oe, rows[i].exp)
            `CHK(level, ~rows[i].exp)
            `CHK(pin5_o, 1'b0)
        end
        {mm, ca, an, fs} <= 4'h0;
        do_reset(3'h4);
        opt <= 3'h0;
        rd(ADDR_STATUS);
        `CHK(d[10:8], 3'h4)
        `CHK(resp, RESP_OKAY)
        wr(ADDR_STATUS, 32'h00000700);
        rd(ADDR_STATUS);
        `CHK(d[10:8], 3'h4)
        wr(ADDR_CTRL, 32'h1);
        repeat (2) @(posedge aclk);
        `CHK(pin5_oe, 1'b1)
        rd(ADDR_CTRL);
        `CHK(d, 32'h1)
        fs <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK(pin5_oe, 1'b0)
        fs <= 1'b0;
        wr(ADDR_CTRL, 32'h0);
        repeat (2) @(posedge aclk);
        `CHK(pin5_oe, 1'b0)
        wr(8'hF0, 32'h1);
        `CHK(resp, RESP_SLVERR)
        wr(ADDR_IRQ_MASK, 32'h1);
        wr(ADDR_IRQ_STAT, 32'hF);
        mm <= 1'b1;
        repeat (3) @(posedge aclk);
        `CHK(irq, 1'b1)
        wr(ADDR_IRQ_STAT, 32'hF);
        @(posedge aclk);
        `CHK(irq, 1'b0)
        wr(ADDR_IRQ_MASK, 32'h0);
        mm <= 1'b0;
        @(posedge aclk);
        mm <= 1'b1;
        repeat (3) @(posedge aclk);
        `CHK(irq, 1'b0)
        meas <= 16'd32000;
        do_reset(3'h5);
        clr <= 1'b0;
        repeat (41000) @(posedge aclk);
        `CHK(pulses, 8'h02)
        final_report();
    end
endmodule // pin5_output_tb_top
